//--- rtl/amac_top.sv
// Implementation choices: the AXI4-Lite interface to the registers and the address map.
`timescale 1ns/1ns
`default_nettype none
// Contract
// - parameter writes accepted only in calibration mode, else locked.
// - calibration mode forces log analog output to full scale.
// - calibration mode uses slower, heavier display averaging.
// - latch switch left: high alarm clears when level drops below point.
// - latch switch right: high alarm held until low or high button pressed or remote clear line pulled low.
// - low alarm is always non-latching.
// - range switch picks one-decimal or whole-unit display range.
// - single-beep limits low and high alarm audio to one half-second beep.
// - fault audio stays a steady tone even in single-beep mode.
// - serial report every two seconds, none in calibration mode.
// - report carries displayed value plus every status light state.
// - overload trips fault light and forces overload display code.
// - fault and high alarm open-drain outputs pull low while active.
// - three fail-safe relays energized normally, released on condition.
// - low alarm audio beeps once per second unless single-beep.
// - high alarm audio beeps four times per second unless single-beep.
// - over-range shows dashed code and raises both alarms.
module amac_top
    import amac_pkg::*;
#(
    parameter int unsigned REPORT_CYCLES = REPORT_CYC,
    parameter int unsigned SLOW_CYCLES = SLOW_BEEP_CYC,
    parameter int unsigned FAST_CYCLES = FAST_BEEP_CYC,
    parameter int unsigned SINGLE_CYCLES = SINGLE_BEEP_CYC,
    parameter int unsigned DEB_CYCLES = DEBOUNCE_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic sw_cal_mode,
    input wire logic sw_latch_high,
    input wire logic sw_range_wide,
    input wire logic sw_single_beep,
    input wire logic btn_low_alarm,
    input wire logic btn_high_alarm,
    input wire logic external_clear_n,
    input wire logic [15:0] count_reading,
    input wire logic count_valid,
    input wire logic overload_trip,
    input wire logic over_range,
    input wire logic detector_fault,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [7:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic irq,
    output logic [15:0] display_value,
    output logic display_decimal,
    output logic [11:0] analog_out,
    output logic [3:0] status_lights,
    output logic audio_out,
    output logic fault_od_out,
    output logic fault_od_oe,
    output logic high_alarm_od_out,
    output logic high_alarm_od_oe,
    output logic relay_low_energize,
    output logic relay_high_energize,
    output logic relay_fault_energize,
    output logic report_valid,
    output logic [19:0] serial_report_out
);
    initial begin
        if (REPORT_CYCLES < 1 || SLOW_CYCLES < 2 || FAST_CYCLES < 2 || SINGLE_CYCLES < 1)
            $error("amac_top: bad timing parameters");
    end
    // =========================================
    // switch and button conditioning
    logic [N_SW-1:0] sw_lvl, sw_rise;
    amac_debounce #(.WIDTH(N_SW), .HOLD_CYC(DEB_CYCLES)) u_deb (
        .clock(clock),
        .rst(rst),
        .raw({~external_clear_n, btn_high_alarm, btn_low_alarm, sw_single_beep,
              sw_range_wide, sw_latch_high, sw_cal_mode}),
        .level(sw_lvl),
        .rise(sw_rise)
    );
    wire cal_mode = sw_lvl[0];
    wire latch_mode = sw_lvl[1];
    wire range_wide = sw_lvl[2];
    wire single_beep = sw_lvl[3];
    wire ack_press = sw_rise[4] | sw_rise[5] | sw_rise[6];

    // =========================================
    // bus slave
    logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
    logic [7:0] awaddr_r;
    logic [31:0] wdata_r, rdata_r;
    logic [1:0] bresp_r, rresp_r;
    logic [15:0] low_pt_r, high_pt_r;
    logic [3:0] irq_stat_r, irq_mask_r;
    logic [15:0] filt_r;
    logic [15:0] display_r;
    wire do_write = aw_hold_r & w_hold_r & ~bvalid_r;
    wire wr_ok = cal_mode | (awaddr_r == OFS_IRQ_STAT) | (awaddr_r == OFS_IRQ_MASK);
    wire wr_known = (awaddr_r == OFS_LOW_PT) | (awaddr_r == OFS_HIGH_PT)
        | (awaddr_r == OFS_IRQ_STAT) | (awaddr_r == OFS_IRQ_MASK);
    wire wr_low = do_write & cal_mode & (awaddr_r == OFS_LOW_PT);
    wire wr_high = do_write & cal_mode & (awaddr_r == OFS_HIGH_PT);
    logic [3:0] wstrb_r;
    wire wr_istat = do_write & (awaddr_r == OFS_IRQ_STAT) & wstrb_r[0];
    wire wr_imask = do_write & (awaddr_r == OFS_IRQ_MASK) & wstrb_r[0];
    wire [15:0] wr_val = {wstrb_r[1] ? wdata_r[15:8] : 8'h00,
                          wstrb_r[0] ? wdata_r[7:0] : 8'h00};
    assign s_axi_awready = ~aw_hold_r;
    assign s_axi_wready = ~w_hold_r;
    assign s_axi_arready = ~rvalid_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;

    logic low_act, high_act_r, fault_act;
    wire [3:0] lights = {~(low_act | high_act_r | fault_act), fault_act, high_act_r, low_act};
    logic [31:0] rd_mux;
    logic rd_known;
    always_comb begin
        rd_known = 1'b1;
        unique case (s_axi_araddr)
            OFS_CTRL: rd_mux = {28'h0, single_beep, range_wide, latch_mode, cal_mode};
            OFS_STATUS: rd_mux = {28'h0, lights};
            OFS_IRQ_STAT: rd_mux = {28'h0, irq_stat_r};
            OFS_IRQ_MASK: rd_mux = {28'h0, irq_mask_r};
            OFS_LOW_PT: rd_mux = {16'h0, low_pt_r};
            OFS_HIGH_PT: rd_mux = {16'h0, high_pt_r};
            OFS_READING: rd_mux = {16'h0, filt_r};
            OFS_DISPLAY: rd_mux = {16'h0, display_r};
            default: begin
                rd_mux = 32'h0;
                rd_known = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid_r <= 1'b0;
            rvalid_r <= 1'b0;
            awaddr_r <= 8'h00;
            wdata_r <= 32'h0;
            wstrb_r <= 4'h0;
            bresp_r <= RESP_OKAY;
            rdata_r <= 32'h0;
            rresp_r <= RESP_OKAY;
        end else begin
            if (s_axi_awvalid && !aw_hold_r) begin
                aw_hold_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && !w_hold_r) begin
                w_hold_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            if (do_write) begin
                bvalid_r <= 1'b1;
                bresp_r <= (wr_known && wr_ok) ? RESP_OKAY : RESP_SLVERR;
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
                aw_hold_r <= 1'b0;
                w_hold_r <= 1'b0;
            end
            if (s_axi_arvalid && !rvalid_r) begin
                rvalid_r <= 1'b1;
                rdata_r <= rd_mux;
                rresp_r <= rd_known ? RESP_OKAY : RESP_SLVERR;
            end else if (rvalid_r && s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // =========================================
    // alarm points and reading filter
    wire [15:0] filt_step = cal_mode ? 16'((32'(count_reading) - 32'(filt_r)) >>> FILT_SHIFT_CAL)
                                     : 16'((32'(count_reading) - 32'(filt_r)) >>> FILT_SHIFT_NORM);
    always_ff @(posedge clock) begin
        if (rst) begin
            low_pt_r <= LOW_PT_RST;
            high_pt_r <= HIGH_PT_RST;
            filt_r <= 16'h0000;
        end else begin
            if (wr_low) low_pt_r <= wr_val;
            if (wr_high) high_pt_r <= wr_val;
            if (count_valid) filt_r <= filt_r + filt_step;
        end
    end

    // =========================================
    // alarm evaluation
    wire low_cond = (filt_r >= low_pt_r) | over_range;
    wire high_cond = (filt_r >= high_pt_r) | over_range;
    assign low_act = low_cond;
    assign fault_act = overload_trip | detector_fault;
    always_ff @(posedge clock) begin
        if (rst) begin
            high_act_r <= 1'b0;
        end else if (high_cond) begin
            high_act_r <= 1'b1;
        end else if (!latch_mode || ack_press) begin
            high_act_r <= 1'b0;
        end
    end

    // =========================================
    // audio
    logic [31:0] beep_cnt_r;
    logic [31:0] single_cnt_r;
    logic low_prev_r, high_prev_r;
    wire [31:0] beep_period = high_act_r ? 32'(FAST_CYCLES) : 32'(SLOW_CYCLES);
    wire alarm_any = low_act | high_act_r;
    wire alarm_start = (low_act & ~low_prev_r) | (high_act_r & ~high_prev_r);
    always_ff @(posedge clock) begin
        if (rst) begin
            beep_cnt_r <= 32'h0;
            single_cnt_r <= 32'h0;
            low_prev_r <= 1'b0;
            high_prev_r <= 1'b0;
        end else begin
            low_prev_r <= low_act;
            high_prev_r <= high_act_r;
            if (!alarm_any || beep_cnt_r >= beep_period - 32'h1) beep_cnt_r <= 32'h0;
            else beep_cnt_r <= beep_cnt_r + 32'h1;
            if (alarm_start) single_cnt_r <= 32'(SINGLE_CYCLES);
            else if (single_cnt_r != 32'h0) single_cnt_r <= single_cnt_r - 32'h1;
        end
    end
    wire beep_on = alarm_any & (beep_cnt_r < (beep_period >> 1));
    wire alarm_tone = single_beep ? (single_cnt_r != 32'h0) : beep_on;
    assign audio_out = fault_act | alarm_tone;

    // =========================================
    // display, analog, lights, pins
    wire [15:0] disp_nxt = overload_trip ? DISP_OVERLOAD :
                           over_range ? DISP_OVERRANGE : filt_r;
    always_ff @(posedge clock) begin
        if (rst) display_r <= 16'h0000;
        else display_r <= disp_nxt;
    end
    assign display_value = display_r;
    assign display_decimal = ~range_wide;
    assign analog_out = cal_mode ? ANALOG_FULL : filt_r[15:4];
    assign status_lights = lights;
    assign fault_od_out = 1'b0;
    assign fault_od_oe = fault_act;
    assign high_alarm_od_out = 1'b0;
    assign high_alarm_od_oe = high_act_r;
    assign relay_low_energize = ~low_act;
    assign relay_high_energize = ~high_act_r;
    assign relay_fault_energize = ~fault_act;

    // =========================================
    // periodic report and interrupts
    logic [31:0] rep_cnt_r;
    logic rep_valid_r;
    logic [19:0] rep_data_r;
    wire rep_fire = ~cal_mode & (rep_cnt_r >= REPORT_CYCLES - 1);
    always_ff @(posedge clock) begin
        if (rst) begin
            rep_cnt_r <= 32'h0;
            rep_valid_r <= 1'b0;
            rep_data_r <= 20'h0;
            irq_stat_r <= 4'h0;
            irq_mask_r <= 4'h0;
        end else begin
            rep_valid_r <= rep_fire;
            if (cal_mode || rep_fire) rep_cnt_r <= 32'h0;
            else rep_cnt_r <= rep_cnt_r + 32'h1;
            if (rep_fire) rep_data_r <= {lights, display_r};
            irq_stat_r <= (irq_stat_r & ~(wr_istat ? wr_val[3:0] : 4'h0))
                | {rep_fire, fault_act, high_act_r, low_act};
            if (wr_imask) irq_mask_r <= wr_val[3:0];
        end
    end
    assign report_valid = rep_valid_r;
    assign serial_report_out = rep_data_r;
    assign irq = |(irq_stat_r & irq_mask_r);

    // =========================================
    // checks
    relay_fault_a: assert property (@(posedge clock) disable iff (rst)
        fault_act |-> !relay_fault_energize && fault_od_oe && audio_out)
        else $error("fault not shown");
    analog_cal_a: assert property (@(posedge clock) disable iff (rst)
        cal_mode |-> analog_out == ANALOG_FULL) else $error("analog not full");
    no_report_a: assert property (@(posedge clock) disable iff (rst)
        $past(cal_mode) |-> !report_valid) else $error("report in cal");
    high_latch_a: assert property (@(posedge clock) disable iff (rst)
        high_act_r && latch_mode && !ack_press |=> high_act_r)
        else $error("latch lost");
    high_auto_a: assert property (@(posedge clock) disable iff (rst)
        !latch_mode && !high_cond |=> !high_act_r) else $error("no auto clear");
    low_follow_a: assert property (@(posedge clock) disable iff (rst)
        relay_low_energize == !low_act) else $error("low relay wrong");
    overload_disp_a: assert property (@(posedge clock) disable iff (rst)
        overload_trip |=> display_value == DISP_OVERLOAD) else $error("no OL code");
    range_alarm_a: assert property (@(posedge clock) disable iff (rst)
        over_range |=> high_act_r) else $error("over-range no alarm");
    lock_a: assert property (@(posedge clock) disable iff (rst)
        !cal_mode |=> $stable(low_pt_r) && $stable(high_pt_r)) else $error("write lock");
endmodule
`default_nettype wire

//--- rtl/amac_pkg.sv
package amac_pkg;
    localparam int unsigned CLK_HZ = 50_000_000;
    // timing figures in milliseconds
    localparam int unsigned DEBOUNCE_MS = 20;
    localparam int unsigned REPORT_MS = 2000;
    localparam int unsigned SLOW_BEEP_MS = 1000;
    localparam int unsigned FAST_BEEP_MS = 250;
    localparam int unsigned SINGLE_BEEP_MS = 500;
    localparam int unsigned DEBOUNCE_CYC = CLK_HZ / 1000 * DEBOUNCE_MS;
    localparam int unsigned REPORT_CYC = CLK_HZ / 1000 * REPORT_MS;
    localparam int unsigned SLOW_BEEP_CYC = CLK_HZ / 1000 * SLOW_BEEP_MS;
    localparam int unsigned FAST_BEEP_CYC = CLK_HZ / 1000 * FAST_BEEP_MS;
    localparam int unsigned SINGLE_BEEP_CYC = CLK_HZ / 1000 * SINGLE_BEEP_MS;
    // filter shift: normal and calibration response
    localparam int unsigned FILT_SHIFT_NORM = 2;
    localparam int unsigned FILT_SHIFT_CAL = 5;
    // register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;
    localparam logic [7:0] OFS_LOW_PT = 8'h10;
    localparam logic [7:0] OFS_HIGH_PT = 8'h14;
    localparam logic [7:0] OFS_READING = 8'h18;
    localparam logic [7:0] OFS_DISPLAY = 8'h1C;
    // display codes
    localparam logic [15:0] DISP_OVERLOAD = 16'hF0F1;
    localparam logic [15:0] DISP_OVERRANGE = 16'hFFFF;
    localparam logic [15:0] LOW_PT_RST = 16'h03E8;
    localparam logic [15:0] HIGH_PT_RST = 16'h2710;
    localparam logic [11:0] ANALOG_FULL = 12'hFFF;
    // status light bits
    localparam int unsigned LT_LOW = 0;
    localparam int unsigned LT_HIGH = 1;
    localparam int unsigned LT_FAULT = 2;
    localparam int unsigned LT_OK = 3;
    localparam int unsigned N_SW = 7;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

//--- rtl/amac_debounce.sv
`timescale 1ns/1ns
`default_nettype none
module amac_debounce
    import amac_pkg::*;
#(
    parameter int unsigned WIDTH = N_SW,
    parameter int unsigned HOLD_CYC = DEBOUNCE_CYC
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [WIDTH-1:0] raw,
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);
    initial begin
        if (WIDTH < 1 || HOLD_CYC < 1) $error("amac_debounce: bad parameters");
    end
    // =========================================
    // per input synchroniser and stability counter
    genvar g;
    for (g = 0; g < WIDTH; g++) begin : g_ch
        logic s1_r, s2_r, lvl_r, rise_r;
        logic [31:0] cnt_r;
        always_ff @(posedge clock) begin
            if (rst) begin
                s1_r <= 1'b0;
                s2_r <= 1'b0;
                lvl_r <= 1'b0;
                rise_r <= 1'b0;
                cnt_r <= '0;
            end else begin
                s1_r <= raw[g];
                s2_r <= s1_r;
                rise_r <= 1'b0;
                if (s2_r == lvl_r) begin
                    cnt_r <= '0;
                end else if (cnt_r >= HOLD_CYC - 1) begin
                    cnt_r <= '0;
                    lvl_r <= s2_r;
                    rise_r <= s2_r;
                end else begin
                    cnt_r <= cnt_r + 32'h1;
                end
            end
        end
        assign level[g] = lvl_r;
        assign rise[g] = rise_r;
    end
endmodule
`default_nettype wire

//--- testbench/amac_logger.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================
// logging computer: collects reports, drives the remote clear line
module amac_logger #(
    parameter int unsigned HOLD = 10
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic report_valid,
    input wire logic [19:0] serial_report_out,
    input wire logic clear_req,
    output logic external_clear_n,
    output logic [19:0] last_rpt,
    output int rpt_cnt,
    output int gap
);
    int since;
    int hold;
    assign external_clear_n = (hold == 0);
    always_ff @(posedge clock) begin
        if (rst) begin
            rpt_cnt <= 0;
            since <= 0;
            gap <= 0;
            hold <= 0;
            last_rpt <= 20'h00000;
        end else begin
            since <= since + 1;
            if (clear_req) begin
                hold <= HOLD;
            end else if (hold != 0) begin
                hold <= hold - 1;
            end
            if (report_valid) begin
                last_rpt <= serial_report_out;
                rpt_cnt <= rpt_cnt + 1;
                gap <= since + 1;
                since <= 0;
            end
        end
    end
endmodule
`default_nettype wire

//--- testbench/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
    import amac_pkg::*;
;
    // ==========================================
    // signals
    logic clock, rst = 1'b1, cal = 1'b0, latch = 1'b0, wide = 1'b0, single = 1'b0;
    logic b_low = 1'b0, b_high = 1'b0, cnt_v = 1'b1, ovl = 1'b0, orng = 1'b0, dfault = 1'b0;
    logic clr_req = 1'b0, awv = 1'b0, wv = 1'b0, bready = 1'b0, arv = 1'b0, rready = 1'b0;
    logic [15:0] cnt = 16'h0000;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awready, wready, bvalid, arready, rvalid, irq, dec, audio, f_out, f_oe, h_out, h_oe;
    logic rl_low, rl_high, rl_fault, rpt_v, clr_n, f_pin, h_pin;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [15:0] disp;
    logic [11:0] analog;
    logic [3:0] lt;
    logic [19:0] rpt, last_rpt;
    int rpt_cnt, gap, error_cnt, tests_run;
    assign f_pin = f_oe ? f_out : 1'b1;
    assign h_pin = h_oe ? h_out : 1'b1;
    amac_top #(.REPORT_CYCLES(100), .SLOW_CYCLES(40), .FAST_CYCLES(10), .SINGLE_CYCLES(20),
        .DEB_CYCLES(4)) DUT (
        .clock(clock), .rst(rst), .sw_cal_mode(cal), .sw_latch_high(latch),
        .sw_range_wide(wide), .sw_single_beep(single), .btn_low_alarm(b_low),
        .btn_high_alarm(b_high), .external_clear_n(clr_n), .count_reading(cnt),
        .count_valid(cnt_v), .overload_trip(ovl), .over_range(orng), .detector_fault(dfault),
        .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_awaddr(awaddr),
        .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
        .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_araddr(araddr),
        .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .irq(irq), .display_value(disp), .display_decimal(dec),
        .analog_out(analog), .status_lights(lt), .audio_out(audio), .fault_od_out(f_out),
        .fault_od_oe(f_oe), .high_alarm_od_out(h_out), .high_alarm_od_oe(h_oe),
        .relay_low_energize(rl_low), .relay_high_energize(rl_high),
        .relay_fault_energize(rl_fault), .report_valid(rpt_v), .serial_report_out(rpt));
    amac_logger #(.HOLD(10)) logger (.clock(clock), .rst(rst), .report_valid(rpt_v),
        .serial_report_out(rpt), .clear_req(clr_req), .external_clear_n(clr_n),
        .last_rpt(last_rpt), .rpt_cnt(rpt_cnt), .gap(gap));
    // ==========================================
    // helpers
    task automatic test_done();
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", nm, e, g);
            error_cnt++;
        end
    endtask
    task automatic rng(input string nm, input int lo, input int hi, input int g);
        tests_run++;
        if (g < lo || g > hi) begin
            $display("ERROR %s expected %0d..%0d seen %0d", nm, lo, hi, g);
            error_cnt++;
        end
    endtask
    task automatic fail_wait(input string nm);
        $display("ERROR %s expected answer seen timeout", nm);
        error_cnt++;
        test_done();
    endtask
    task automatic go(input int n);
        repeat (n) @(posedge clock);
    endtask
    task automatic wait_lt(input int i, input logic v);
        int n;
        for (n = 0; lt[i] !== v; n++) begin
            if (n > 3000) fail_wait("status light");
            @(posedge clock);
        end
        go(2);
    endtask
    task automatic meas(input int n, output int e, output int h);
        logic p;
        p = audio;
        e = 0;
        h = 0;
        repeat (n) begin
            @(posedge clock);
            e += (audio && !p);
            h += audio;
            p = audio;
        end
    endtask
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        int n;
        @(posedge clock);
        awv <= 1'b1;
        awaddr <= a;
        wv <= 1'b1;
        wdata <= d;
        bready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (awv && awready) awv <= 1'b0;
            if (wv && wready) wv <= 1'b0;
            if (bvalid === 1'b1) begin
                r = bresp;
                bready <= 1'b0;
                return;
            end
        end
        fail_wait("write response");
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input logic [1:0] er);
        int n;
        @(posedge clock);
        arv <= 1'b1;
        araddr <= a;
        rready <= 1'b1;
        for (n = 0; n < 100; n++) begin
            @(posedge clock);
            if (arv && arready) arv <= 1'b0;
            if (rvalid === 1'b1) begin
                chk("read data", e, rdata & m);
                chk("read resp", {30'h0, er}, {30'h0, rresp});
                rready <= 1'b0;
                return;
            end
        end
        fail_wait("read response");
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset();
        logic [1:0] r;
        chk("relays", 3'b111, {rl_low, rl_high, rl_fault});
        chk("pins", 2'b11, {f_pin, h_pin});
        chk("lights", 4'b1000, lt);
        rchk(OFS_HIGH_PT, 32'hFFFF, 32'h2710, RESP_OKAY);
        rchk(8'h40, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
        axw(8'h40, 32'h1, r);
        chk("unmapped write", RESP_SLVERR, r);
        $display("test reset done");
    endtask
    task automatic t_report();
        int c, n;
        logic a;
        logic [1:0] r;
        c = rpt_cnt;
        for (n = 0; rpt_cnt < c + 2; n++) begin
            if (n > 300) fail_wait("report");
            @(posedge clock);
        end
        chk("report gap", 100, gap);
        chk("report data", {lt, disp}, last_rpt);
        rchk(OFS_IRQ_STAT, 32'h8, 32'h8, RESP_OKAY);
        axw(OFS_IRQ_MASK, 32'h0, r);
        go(2);
        a = irq;
        axw(OFS_IRQ_MASK, 32'hF, r);
        go(2);
        chk("irq mask", {31'h0, ~a}, {31'h0, irq});
        $display("test report done");
    endtask
    task automatic t_param();
        int c;
        logic [1:0] r;
        chk("analog out", 0, analog);
        axw(OFS_LOW_PT, 32'h500, r);
        chk("locked write", RESP_SLVERR, r);
        rchk(OFS_LOW_PT, 32'hFFFF, 32'h3E8, RESP_OKAY);
        cal <= 1'b1;
        go(12);
        chk("analog full", ANALOG_FULL, analog);
        wstrb <= 4'h1;
        axw(OFS_LOW_PT, 32'h1234, r);
        chk("open write", RESP_OKAY, r);
        rchk(OFS_LOW_PT, 32'hFFFF, 32'h34, RESP_OKAY);
        cnt <= 16'h0400;
        go(1);
        cnt_v <= 1'b0;
        rchk(OFS_READING, 32'hFFFF, 32'h400 >> FILT_SHIFT_CAL, RESP_OKAY);
        cnt <= 16'h0000;
        cnt_v <= 1'b1;
        axw(OFS_IRQ_STAT, 32'hF, r);
        c = rpt_cnt;
        go(250);
        chk("no report", c, rpt_cnt);
        rchk(OFS_IRQ_STAT, 32'hF, 32'h0, RESP_OKAY);
        chk("irq cleared", 0, irq);
        cal <= 1'b0;
        go(12);
        $display("test parameters done");
    endtask
    task automatic t_range();
        chk("one decimal", 1, dec);
        wide <= 1'b1;
        go(2);
        wide <= 1'b0;
        go(10);
        chk("glitch ignored", 1, dec);
        wide <= 1'b1;
        go(12);
        chk("whole units", 0, dec);
        rchk(OFS_CTRL, 32'hF, 32'h4, RESP_OKAY);
        wide <= 1'b0;
        go(12);
        $display("test range done");
    endtask
    task automatic t_low();
        int e, h;
        cnt <= 16'h0800;
        wait_lt(LT_LOW, 1'b1);
        chk("no high", 0, lt[LT_HIGH]);
        chk("low relay", 0, rl_low);
        meas(400, e, h);
        rng("slow beeps", 9, 11, e);
        cnt <= 16'h0000;
        wait_lt(LT_LOW, 1'b0);
        chk("low relay", 1, rl_low);
        single <= 1'b1;
        go(12);
        cnt <= 16'h0800;
        wait_lt(LT_LOW, 1'b1);
        meas(400, e, h);
        rng("single beep", 1, 21, h);
        cnt <= 16'h0000;
        wait_lt(LT_LOW, 1'b0);
        $display("test low alarm done");
    endtask
    task automatic t_fault();
        int e, h;
        ovl <= 1'b1;
        wait_lt(LT_FAULT, 1'b1);
        chk("overload code", DISP_OVERLOAD, disp);
        rchk(OFS_DISPLAY, 32'hFFFF, DISP_OVERLOAD, RESP_OKAY);
        chk("fault pin", 0, f_pin);
        chk("fault relay", 0, rl_fault);
        meas(100, e, h);
        rng("fault tone", 100, 100, h);
        rchk(OFS_IRQ_STAT, 32'h4, 32'h4, RESP_OKAY);
        ovl <= 1'b0;
        dfault <= 1'b1;
        go(5);
        chk("fault light", 1, lt[LT_FAULT]);
        dfault <= 1'b0;
        wait_lt(LT_FAULT, 1'b0);
        chk("fault relay", 1, rl_fault);
        single <= 1'b0;
        orng <= 1'b1;
        wait_lt(LT_HIGH, 1'b1);
        chk("over low", 1, lt[LT_LOW]);
        chk("dash code", DISP_OVERRANGE, disp);
        orng <= 1'b0;
        wait_lt(LT_HIGH, 1'b0);
        $display("test fault done");
    endtask
    task automatic t_high();
        int e, h, k;
        cnt <= 16'h3000;
        wait_lt(LT_HIGH, 1'b1);
        chk("high relay", 0, rl_high);
        chk("high pin", 0, h_pin);
        meas(400, e, h);
        rng("fast beeps", 39, 41, e);
        cnt <= 16'h0000;
        wait_lt(LT_HIGH, 1'b0);
        chk("high pin", 1, h_pin);
        latch <= 1'b1;
        go(12);
        for (k = 0; k < 3; k++) begin
            cnt <= 16'h3000;
            wait_lt(LT_HIGH, 1'b1);
            cnt <= 16'h0000;
            wait_lt(LT_LOW, 1'b0);
            go(100);
            chk("latched high", 1, lt[LT_HIGH]);
            b_high <= (k == 0);
            b_low <= (k == 1);
            clr_req <= (k == 2);
            go(1);
            clr_req <= 1'b0;
            go(9);
            b_high <= 1'b0;
            b_low <= 1'b0;
            wait_lt(LT_HIGH, 1'b0);
        end
        $display("test high alarm done");
    endtask
    // ==========================================
    // run
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end
    initial begin
        error_cnt = 0;
        tests_run = 0;
        go(16);
        rst <= 1'b0;
        go(12);
        t_reset();
        t_report();
        t_param();
        t_range();
        t_low();
        t_fault();
        t_high();
        test_done();
    end
endmodule
`default_nettype wire
